//--- hw/lidc_regs.sv
`timescale 1ns/1ps
`default_nettype none
module lidc_regs #(
  parameter int              ADDR_W  = 8,
  parameter logic [15:0]     VERSION = lidc_pkg::VERSION_DEFAULT
) (
  input  wire logic                      clk,
  input  wire logic                      resetn,
  input  wire logic [ADDR_W-1:0]         host_addr,
  input  wire logic [7:0]                host_wdata,
  input  wire logic                      host_wr,
  input  wire logic                      host_rd,
  output logic      [7:0]                host_rdata,
  input  wire logic                      bus_reset,
  input  wire logic                      tree_id_done,
  input  wire logic [5:0]                phy_node_number,
  input  wire logic                      self_id_done,
  input  wire logic                      sid_quad_valid,
  input  wire logic [31:0]               sid_quad_data,
  output logic                           aq_valid,
  output logic      [31:0]               aq_data,
  output logic                           aq_first,
  output logic                           aq_last,
  input  wire logic                      rx_hdr_valid,
  input  wire logic [15:0]               rx_dest_id,
  input  wire logic                      rx_busy_needed,
  input  wire logic                      rx_pkt_dual,
  output logic                           rx_accept,
  output logic                           ack_valid,
  output logic                           ack_busy,
  output lidc_pkg::lidc_busy_code_t      ack_code,
  input  wire logic                      tx_pending,
  output logic                           tx_arb_req,
  output logic                           tx_send_ok,
  output logic      [15:0]               tx_source_id,
  output logic                           receiver_enable
);
  import lidc_pkg::*;

  // Byte lanes take two address bits and the control word needs a third.
  if (ADDR_W < 3) begin : g_addr_w_check
    $error("lidc_regs: ADDR_W must be at least 3");
  end

  typedef struct packed {
    logic [9:0]      segment_number;
    logic [5:0]      node_number;
    logic            identity_valid;
    logic            self_ident_capture;
    lidc_busy_ctl_t  busy_ctl;
    logic            tx_enable;
    logic            rx_enable;
    lidc_state_t     state;
    logic            sid_any;
    logic [7:0]      rdata;
    logic            aq_valid;
    logic [31:0]     aq_data;
    logic            aq_first;
    logic            aq_last;
    logic            rx_accept;
  } lidc_st_t;

  lidc_st_t s_q;
  lidc_st_t s_d;

  logic [31:0]     ident_word;
  logic [31:0]     lctl_word;
  logic [31:0]     rd_word;
  logic            hit_ident;
  logic            hit_lctl;
  logic [1:0]      lane;
  logic [31:0]     lctl_new;
  logic            busy_phase;
  logic            own_match;

  // The busy decision runs a cycle behind the accept, when the receive FIFO level is known.
  lidc_busy_ack u_busy (
    .clk         (clk),
    .resetn      (resetn),
    .busy_ctl    (s_q.busy_ctl),
    .ack_req     (s_q.rx_accept),
    .busy_needed (rx_busy_needed),
    .pkt_dual    (rx_pkt_dual),
    .ack_valid   (ack_valid),
    .ack_busy    (ack_busy),
    .ack_code    (ack_code),
    .busy_phase  (busy_phase)
  );

  always_comb begin
    ident_word = {s_q.segment_number, s_q.node_number, VERSION};
    lctl_word = 32'h00000000;
    lctl_word[IDV_BIT] = s_q.identity_valid;
    lctl_word[SIDCAP_BIT] = s_q.self_ident_capture;
    lctl_word[BUSY_LSB +: 3] = s_q.busy_ctl;
    lctl_word[TXEN_BIT] = s_q.tx_enable;
    lctl_word[RXEN_BIT] = s_q.rx_enable;
    // The busy flag is status only; host writes never move the phase.
    lctl_word[BFLAG_BIT] = busy_phase;
  end

  always_comb begin
    s_d = s_q;
    lane = host_addr[1:0];
    hit_ident = ({host_addr[ADDR_W-1:2], 2'b00} == ADDR_W'(IDENT_OFS));
    hit_lctl  = ({host_addr[ADDR_W-1:2], 2'b00} == ADDR_W'(LCTL_OFS));
    rd_word = hit_ident ? ident_word : (hit_lctl ? lctl_word : 32'h00000000);
    lctl_new = lctl_word;
    lctl_new[lane*8 +: 8] = host_wdata;

    // Unmapped reads return zero; the byte is held until the next read.
    if (host_rd) begin
      s_d.rdata = rd_word[lane*8 +: 8];
    end

    if (host_wr && hit_ident) begin
      // Only the upper two byte lanes hold writable fields.
      if (lane == 2'd3) begin
        s_d.segment_number[9:2] = host_wdata;
      end
      if (lane == 2'd2) begin
        s_d.segment_number[1:0] = host_wdata[7:6];
        s_d.node_number = host_wdata[5:0];
      end
    end
    // Every writable control field sits in the top byte lane.
    if (host_wr && hit_lctl && lane == 2'd3) begin
      s_d.identity_valid = lctl_new[IDV_BIT];
      s_d.self_ident_capture = lctl_new[SIDCAP_BIT];
      s_d.busy_ctl = lidc_busy_ctl_t'(lctl_new[BUSY_LSB +: 3]);
      s_d.tx_enable = lctl_new[TXEN_BIT];
      s_d.rx_enable = lctl_new[RXEN_BIT];
    end

    s_d.aq_valid = 1'b0;
    s_d.aq_last = 1'b0;
    case (s_q.state)
      LIDC_ST_IDLE: begin
        s_d.state = LIDC_ST_IDLE;
      end
      LIDC_ST_TREE: begin
        if (tree_id_done) begin
          // The physical layer's node number beats a host write in the same cycle.
          s_d.node_number = phy_node_number;
          s_d.state = LIDC_ST_SID;
        end
      end
      LIDC_ST_SID: begin
        if (sid_quad_valid && s_q.self_ident_capture) begin
          s_d.aq_valid = 1'b1;
          s_d.aq_data = sid_quad_data;
          s_d.aq_first = ~s_q.sid_any;
          s_d.sid_any = 1'b1;
        end
        if (self_id_done) begin
          // Closing marker makes all quadlets one packet in the queue.
          s_d.aq_last = s_q.sid_any & s_q.self_ident_capture;
          s_d.identity_valid = 1'b1;
          s_d.state = LIDC_ST_IDLE;
        end
      end
      // An unused state code falls back to idle rather than wedging the sequence.
      default: begin
        s_d.state = LIDC_ST_IDLE;
      end
    endcase

    // A bus reset overrides a segment number or identity valid write in the same cycle.
    if (bus_reset) begin
      s_d.segment_number = SEG_RESET;
      s_d.identity_valid = 1'b0;
      s_d.sid_any = 1'b0;
      s_d.state = LIDC_ST_TREE;
    end

    // A register write lands one edge before it can steer an accept decision.
    own_match = (rx_dest_id == {s_q.segment_number, s_q.node_number});
    s_d.rx_accept = rx_hdr_valid && s_q.identity_valid && own_match;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '{
        segment_number:     SEG_RESET,
        node_number:        NODE_RESET,
        identity_valid:     LCTL_RESET[IDV_BIT],
        self_ident_capture: LCTL_RESET[SIDCAP_BIT],
        busy_ctl:           lidc_busy_ctl_t'(LCTL_RESET[BUSY_LSB +: 3]),
        tx_enable:          LCTL_RESET[TXEN_BIT],
        rx_enable:          LCTL_RESET[RXEN_BIT],
        state:              LIDC_ST_IDLE,
        sid_any:            1'b0,
        rdata:              8'h00,
        aq_valid:           1'b0,
        aq_data:            32'h00000000,
        aq_first:           1'b0,
        aq_last:            1'b0,
        rx_accept:          1'b0
      };
    end else begin
      s_q <= s_d;
    end
  end

  assign host_rdata      = s_q.rdata;
  assign aq_valid        = s_q.aq_valid;
  assign aq_data         = s_q.aq_data;
  assign aq_first        = s_q.aq_first;
  assign aq_last         = s_q.aq_last;
  assign rx_accept       = s_q.rx_accept;
  // Arbitration is gated here so no request leaks out with the transmitter off.
  assign tx_arb_req      = s_q.tx_enable & tx_pending;
  assign tx_send_ok      = s_q.tx_enable;
  assign tx_source_id    = {s_q.segment_number, s_q.node_number};
  assign receiver_enable = s_q.rx_enable;
endmodule
`default_nettype wire

//--- hw/lidc_pkg.sv
// How it works
// - Segment plus node number form own address.
// - Bus reset forces segment number to ones.
// - Node number loads after tree identification.
// - Low sixteen identity bits are read-only version.
// - Identity valid accepts packets for own node.
// - Hardware sets identity valid after self-ID.
// - Capture bit queues self-ID packets as one.
// - Code 000 follows packet's requested retry protocol.
// - Codes 001/010 force busy A/B when needed.
// - 011 single phase; 111 single phase, always busy.
// - Code 100 follows packet protocol, always busy.
// - Codes 101/110 busy A/B every packet.
// - Transmitter enable allows arbitration and sending.
`default_nettype none
package lidc_pkg;
  localparam logic [7:0]  IDENT_OFS        = 8'h00;
  localparam logic [7:0]  LCTL_OFS         = 8'h04;
  localparam int          SEG_LSB          = 22;
  localparam int          NODE_LSB         = 16;
  localparam int          IDV_BIT          = 31;
  localparam int          SIDCAP_BIT       = 30;
  localparam int          BUSY_LSB         = 27;
  localparam int          TXEN_BIT         = 26;
  localparam int          RXEN_BIT         = 25;
  localparam int          BFLAG_BIT        = 4;
  localparam logic [9:0]  SEG_RESET        = 10'h3FF;
  localparam logic [5:0]  NODE_RESET       = 6'h3F;
  localparam logic [31:0] LCTL_RESET       = 32'h46000000;
  // Arbitrary revision value.
  localparam logic [15:0] VERSION_DEFAULT  = 16'h0001;

  typedef enum logic [2:0] {
    LIDC_BC_PROTO   = 3'h0,
    LIDC_BC_DIAG_A  = 3'h1,
    LIDC_BC_DIAG_B  = 3'h2,
    LIDC_BC_SINGLE  = 3'h3,
    LIDC_BC_PROTO_F = 3'h4,
    LIDC_BC_ALL_A   = 3'h5,
    LIDC_BC_ALL_B   = 3'h6,
    LIDC_BC_SINGLE_F = 3'h7
  } lidc_busy_ctl_t;

  typedef enum logic [1:0] {
    LIDC_ACK_X = 2'h0,
    LIDC_ACK_A = 2'h1,
    LIDC_ACK_B = 2'h2
  } lidc_busy_code_t;

  typedef enum logic [1:0] {
    LIDC_ST_IDLE = 2'b00,
    LIDC_ST_TREE = 2'b01,
    LIDC_ST_SID  = 2'b11
  } lidc_state_t;
endpackage
`default_nettype wire

//--- hw/lidc_busy_ack.sv
`timescale 1ns/1ps
`default_nettype none
module lidc_busy_ack (
  input  wire logic                      clk,
  input  wire logic                      resetn,
  input  wire lidc_pkg::lidc_busy_ctl_t  busy_ctl,
  input  wire logic                      ack_req,
  input  wire logic                      busy_needed,
  input  wire logic                      pkt_dual,
  output logic                           ack_valid,
  output logic                           ack_busy,
  output lidc_pkg::lidc_busy_code_t      ack_code,
  output logic                           busy_phase
);
  import lidc_pkg::*;

  typedef struct packed {
    logic            valid;
    logic            busy;
    lidc_busy_code_t code;
    logic            phase;
  } lidc_ba_st_t;

  lidc_ba_st_t s_q;
  lidc_ba_st_t s_d;
  logic        forced;
  logic        send;
  lidc_busy_code_t code;

  always_comb begin
    s_d = s_q;
    forced = 1'b0;
    code = LIDC_ACK_X;
    case (busy_ctl)
      LIDC_BC_PROTO:    code = pkt_dual ? (s_q.phase ? LIDC_ACK_B : LIDC_ACK_A) : LIDC_ACK_X;
      LIDC_BC_DIAG_A:   code = LIDC_ACK_A;
      LIDC_BC_DIAG_B:   code = LIDC_ACK_B;
      LIDC_BC_SINGLE:   code = LIDC_ACK_X;
      LIDC_BC_PROTO_F: begin
        forced = 1'b1;
        code = pkt_dual ? (s_q.phase ? LIDC_ACK_B : LIDC_ACK_A) : LIDC_ACK_X;
      end
      LIDC_BC_ALL_A: begin
        forced = 1'b1;
        code = LIDC_ACK_A;
      end
      LIDC_BC_ALL_B: begin
        forced = 1'b1;
        code = LIDC_ACK_B;
      end
      LIDC_BC_SINGLE_F: begin
        forced = 1'b1;
        code = LIDC_ACK_X;
      end
      default: code = LIDC_ACK_X;
    endcase
    send = busy_needed | forced;
    s_d.valid = ack_req;
    if (ack_req) begin
      s_d.busy = send;
      s_d.code = send ? code : LIDC_ACK_X;
      // The phase only alternates when a dual-phase busy actually goes out.
      if (send && code != LIDC_ACK_X) begin
        s_d.phase = ~s_q.phase;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '{valid: 1'b0, busy: 1'b0, code: LIDC_ACK_X, phase: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign ack_valid  = s_q.valid;
  assign ack_busy   = s_q.busy;
  assign ack_code   = s_q.code;
  assign busy_phase = s_q.phase;
endmodule
`default_nettype wire

//--- dv/lidc_phy_model.sv
`timescale 1ns/1ps
`default_nettype none
module lidc_phy_model (
  input  wire logic  clk,
  output logic       bus_reset,
  output logic       tree_id_done,
  output logic [5:0] phy_node_number,
  output logic       sid_quad_valid,
  output logic [31:0] sid_quad_data,
  output logic       self_id_done
);
  initial begin
    bus_reset = 1'b0;
    tree_id_done = 1'b0;
    phy_node_number = 6'h2A;
    sid_quad_valid = 1'b0;
    sid_quad_data = 32'h5A5A5A5A;
    self_id_done = 1'b0;
  end
  // Lines that carry no valid value show the inverse of the last one.
  task automatic run(input logic [5:0] node, input int n);
    @(posedge clk);
    bus_reset <= 1'b1;
    @(posedge clk);
    bus_reset <= 1'b0;
    @(posedge clk);
    tree_id_done <= 1'b1;
    phy_node_number <= node;
    @(posedge clk);
    tree_id_done <= 1'b0;
    phy_node_number <= ~node;
    for (int i = 0; i < n; i++) begin
      sid_quad_valid <= 1'b1;
      sid_quad_data <= 32'h81000000 | 32'(i);
      @(posedge clk);
    end
    sid_quad_valid <= 1'b0;
    sid_quad_data <= ~sid_quad_data;
    self_id_done <= 1'b1;
    @(posedge clk);
    self_id_done <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- dv/lidc_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module lidc_regs_monitor (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        bus_reset,
  input wire logic        tree_id_done,
  input wire logic [5:0]  phy_node_number,
  input wire logic        sid_quad_valid,
  input wire logic [31:0] sid_quad_data,
  input wire logic        self_id_done,
  input wire logic        aq_valid,
  input wire logic [31:0] aq_data,
  input wire logic        aq_last,
  input wire logic        rx_hdr_valid,
  input wire logic        rx_accept,
  input wire logic        ack_valid,
  input wire logic        tx_pending,
  input wire logic        tx_arb_req,
  input wire logic        tx_send_ok,
  input wire logic [15:0] tx_source_id
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_accept_cause: assert property (rx_accept |-> $past(rx_hdr_valid))
    else $error("accept without a header");
  a_ack_follows: assert property (rx_accept |=> ack_valid)
    else $error("accepted packet got no acknowledge");
  a_ack_cause: assert property (ack_valid |-> $past(rx_accept))
    else $error("acknowledge without an accepted packet");
  a_arb_gate: assert property (tx_arb_req == (tx_send_ok && tx_pending))
    else $error("arbitration request not gated by enable");
  a_seg_forced: assert property (bus_reset |=> tx_source_id[15:6] == 10'h3FF)
    else $error("segment not forced by bus reset");
  a_node_load: assert property (bus_reset ##2 tree_id_done |=> tx_source_id[5:0] == $past(phy_node_number))
    else $error("node number not loaded");
  a_quad_capture: assert property (aq_valid |-> $past(sid_quad_valid) && aq_data == $past(sid_quad_data))
    else $error("queued quadlet differs from received one");
  a_last_cause: assert property (aq_last |-> $past(self_id_done))
    else $error("packet end without self-ID completion");
  c_accept: cover property (rx_accept);
  c_ack: cover property (ack_valid);
  c_last: cover property (aq_last);
endmodule
bind lidc_regs lidc_regs_monitor i_lidc_regs_monitor (.clk(clk), .resetn(resetn), .bus_reset(bus_reset),
  .tree_id_done(tree_id_done), .phy_node_number(phy_node_number), .sid_quad_valid(sid_quad_valid),
  .sid_quad_data(sid_quad_data), .self_id_done(self_id_done), .aq_valid(aq_valid), .aq_data(aq_data),
  .aq_last(aq_last), .rx_hdr_valid(rx_hdr_valid), .rx_accept(rx_accept), .ack_valid(ack_valid),
  .tx_pending(tx_pending), .tx_arb_req(tx_arb_req), .tx_send_ok(tx_send_ok), .tx_source_id(tx_source_id));
`default_nettype wire

//--- dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import lidc_pkg::*;
  localparam logic [15:0] VER = 16'hA5C3; // Arbitrary revision value.
  logic clk = 0, resetn = 0, host_wr = 0, host_rd = 0, rx_hdr_valid = 0, rx_busy_needed = 0, rx_pkt_dual = 0;
  logic tx_pending = 0, bus_reset, tree_id_done, self_id_done, sid_quad_valid, aq_valid, aq_first, aq_last;
  logic rx_accept, ack_valid, ack_busy, tx_arb_req, tx_send_ok, receiver_enable;
  logic [7:0] host_addr = 8'h00, host_wdata = 8'h00, host_rdata, rd_q;
  logic [15:0] rx_dest_id = 16'h0000, tx_source_id;
  logic [5:0] phy_node_number;
  logic [31:0] sid_quad_data, aq_data;
  lidc_busy_code_t ack_code;
  int bad_count = 0, checks_done = 0, cycles = 0, aq_n = 0, first_n = 0, last_n = 0;
  always #10 clk = ~clk;
  lidc_regs #(.VERSION(VER)) i_lidc_regs (.clk(clk), .resetn(resetn), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_wr(host_wr), .host_rd(host_rd), .host_rdata(host_rdata),
    .bus_reset(bus_reset), .tree_id_done(tree_id_done), .phy_node_number(phy_node_number),
    .self_id_done(self_id_done), .sid_quad_valid(sid_quad_valid), .sid_quad_data(sid_quad_data),
    .aq_valid(aq_valid), .aq_data(aq_data), .aq_first(aq_first), .aq_last(aq_last),
    .rx_hdr_valid(rx_hdr_valid), .rx_dest_id(rx_dest_id), .rx_busy_needed(rx_busy_needed),
    .rx_pkt_dual(rx_pkt_dual), .rx_accept(rx_accept), .ack_valid(ack_valid), .ack_busy(ack_busy),
    .ack_code(ack_code), .tx_pending(tx_pending), .tx_arb_req(tx_arb_req), .tx_send_ok(tx_send_ok),
    .tx_source_id(tx_source_id), .receiver_enable(receiver_enable));
  lidc_phy_model i_lidc_phy_model (.clk(clk), .bus_reset(bus_reset), .tree_id_done(tree_id_done),
    .phy_node_number(phy_node_number), .sid_quad_valid(sid_quad_valid), .sid_quad_data(sid_quad_data),
    .self_id_done(self_id_done));
  always @(posedge clk) begin
    if (aq_valid) aq_n++;
    if (aq_valid && aq_first) first_n++;
    if (aq_last) last_n++;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    host_addr <= a;
    host_wdata <= d;
    host_wr <= 1'b1;
    @(posedge clk);
    host_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    host_addr <= a;
    host_rd <= 1'b1;
    @(posedge clk);
    host_rd <= 1'b0;
    #1 rd_q = host_rdata;
  endtask
  // Busy need and retry type stay driven after the header drops so the late busy sample sees them.
  task automatic pkt(input logic [15:0] dest, input logic need, dual, acc, busy, input logic [1:0] code);
    @(posedge clk);
    rx_hdr_valid <= 1'b1;
    rx_dest_id <= dest;
    rx_busy_needed <= need;
    rx_pkt_dual <= dual;
    @(posedge clk);
    rx_hdr_valid <= 1'b0;
    #1 check(rx_accept, acc);
    @(posedge clk);
    #1 check(ack_valid, acc);
    if (acc) begin
      check(ack_busy, busy);
      check(ack_code, code);
    end
  endtask
  task automatic t_reset();
    rd(8'h03);
    check(rd_q, 8'hFF);
    rd(8'h02);
    check(rd_q, 8'hFF);
    wr(8'h01, 8'h5A);
    rd(8'h01);
    check(rd_q, VER[15:8]);
    rd(8'h00);
    check(rd_q, VER[7:0]);
    rd(8'h07);
    check(rd_q, 8'h46);
    check(tx_source_id, 16'hFFFF);
    check(receiver_enable, 1'b1);
  endtask
  task automatic t_selfid();
    wr(8'h03, 8'h12);
    rd(8'h03);
    check(rd_q, 8'h12);
    wr(8'h02, 8'h07);
    rd(8'h02);
    check(rd_q, 8'h07);
    check(tx_source_id, 16'h1207);
    i_lidc_phy_model.run(6'h05, 3);
    repeat (2) @(posedge clk);
    #1 check(aq_n, 3);
    check(first_n, 1);
    check(last_n, 1);
    rd(8'h03);
    check(rd_q, 8'hFF);
    rd(8'h02);
    check(rd_q, 8'hC5);
    rd(8'h07);
    check(rd_q[7], 1'b1);
    check(tx_source_id, 16'hFFC5);
  endtask
  task automatic t_busy();
    logic [1:0] exp [8] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h0, 2'h1, 2'h2, 2'h0};
    pkt(16'hFFC5, 1'b1, 1'b1, 1'b1, 1'b1, 2'h1);
    pkt(16'hFFC5, 1'b1, 1'b1, 1'b1, 1'b1, 2'h2);
    pkt(16'hFFC4, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0);
    for (int c = 0; c < 8; c++) begin
      wr(8'h07, {2'b11, 3'(c), 3'b110});
      pkt(16'hFFC5, 1'b1, 1'b0, 1'b1, 1'b1, exp[c]);
      pkt(16'hFFC5, 1'b0, 1'b0, 1'b1, c > 3, c > 3 ? exp[c] : 2'h0);
    end
    wr(8'h07, 8'hE6);
    pkt(16'hFFC5, 1'b0, 1'b1, 1'b1, 1'b1, 2'h1);
    pkt(16'hFFC5, 1'b0, 1'b1, 1'b1, 1'b1, 2'h2);
    wr(8'h07, 8'h46);
    pkt(16'hFFC5, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0);
  endtask
  task automatic t_tx();
    @(posedge clk);
    tx_pending <= 1'b1;
    wr(8'h07, 8'hC2);
    check(tx_arb_req, 1'b0);
    check(tx_send_ok, 1'b0);
    wr(8'h07, 8'hC6);
    check(tx_arb_req, 1'b1);
    wr(8'h07, 8'h84);
    check(receiver_enable, 1'b0);
    i_lidc_phy_model.run(6'h09, 2);
    repeat (2) @(posedge clk);
    #1 check(aq_n, 3);
    check(last_n, 1);
    check(tx_source_id, 16'hFFC9);
    rd(8'h07);
    check(rd_q[7], 1'b1);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // The whole run needs well under a thousand cycles.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      conclude();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_selfid();
    t_busy();
    t_tx();
    conclude();
  end
endmodule
`default_nettype wire
